// [src/rcsp_pkg.sv]
// Purpose: shared constants and types of the rate converter and serial ports
// Assumes: one 200 MHz clock, 5 ns period
// Notes: settle counts are in output sample periods
package rcsp_pkg;
    localparam int SAMPLE_W = 24;
    localparam int FIFO_DEPTH = 16;
    localparam logic [1:0] RES_24 = 2'h0;
    localparam logic [1:0] RES_20 = 2'h1;
    localparam logic [1:0] RES_16 = 2'h2;
    localparam logic [1:0] RES_RAW = 2'h3;
    localparam logic [4:0] BITS_24 = 5'h18;
    localparam logic [4:0] BITS_20 = 5'h14;
    localparam logic [4:0] BITS_16 = 5'h10;
    // master bit clock half period in clk cycles, per rate code
    localparam logic [6:0] HALF_RATE0 = 7'h04;
    localparam logic [6:0] HALF_RATE1 = 7'h08;
    localparam logic [6:0] HALF_RATE2 = 7'h10;
    localparam logic [6:0] HALF_RATE3 = 7'h20;
    localparam logic [7:0] RATIO_UNITY = 8'h40;
    localparam logic [7:0] RATIO_MAX = 8'hff;
    localparam logic [7:0] RATIO_TOL = 8'h01;
    localparam logic [5:0] RATIO_WIN_LAST = 6'h3f;
    localparam int SETTLE_CHANGE_FRAMES = 9400;
    localparam int SETTLE_POWERUP_FRAMES = 8300;
    localparam logic [23:0] DITH_TAPS_L = 24'he10000;
    localparam logic [23:0] DITH_TAPS_R = 24'hd80000;
    localparam logic [23:0] DITH_SEED_L = 24'h000001;
    localparam logic [23:0] DITH_SEED_R = 24'h5a5a5a;
    localparam logic [23:0] SAT_POS = 24'h7fffff;

    typedef struct packed {
        logic master;
        logic [1:0] bitclk_rate;
        logic [1:0] resolution;
        logic justify;
        logic first_bit_delay;
        logic bitclk_polarity;
        logic wordclk_polarity;
    } rcsp_port_cfg_s;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } rcsp_stereo_s;

    typedef struct packed {
        logic validity;
        logic user;
        logic chan_status;
    } rcsp_raw_s;
endpackage

// [src/rcsp_top.sv]
// Purpose: rate converter control with serial audio input and output ports
// Assumes: serial pins are asynchronous and pass two flip-flops first
// Notes: converter core modelled as a sample fifo with ratio tracking
`timescale 1ns/10ps

module rcsp_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    // drain side
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;

    assign s_ready = (wptr - rptr) != (AW+1)'(DEPTH);
    assign m_valid = wptr != rptr;
    assign m_data = mem[rptr[AW-1:0]];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (s_valid && s_ready) wptr <= wptr + (AW+1)'(1);
            if (m_valid && m_ready) rptr <= rptr + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (s_valid && s_ready) mem[wptr[AW-1:0]] <= s_data;
    end
endmodule // rcsp_fifo

module rcsp_top #(
    parameter int SETTLE_CHANGE = rcsp_pkg::SETTLE_CHANGE_FRAMES,
    parameter int SETTLE_POWERUP = rcsp_pkg::SETTLE_POWERUP_FRAMES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire rcsp_pkg::rcsp_port_cfg_s in_cfg,
    input wire rcsp_pkg::rcsp_port_cfg_s out_cfg,
    input wire logic src_from_rx,
    input wire logic dither_off,
    input wire logic out_mute,
    input wire logic out_clk_recovered,
    input wire logic recovery_locked,
    // receiver samples
    input wire logic rx_valid,
    input wire rcsp_pkg::rcsp_stereo_s rx_sample,
    input wire rcsp_pkg::rcsp_raw_s rx_raw_left,
    input wire rcsp_pkg::rcsp_raw_s rx_raw_right,
    input wire logic rx_block_start_pin,
    // serial input port pins
    input wire logic in_bit_clock_i,
    output logic in_bit_clock_o,
    output logic in_bit_clock_oe,
    input wire logic in_word_clock_i,
    output logic in_word_clock_o,
    output logic in_word_clock_oe,
    input wire logic in_data,
    // serial output port pins
    input wire logic out_bit_clock_i,
    output logic out_bit_clock_o,
    output logic out_bit_clock_oe,
    input wire logic out_word_clock_i,
    output logic out_word_clock_o,
    output logic out_word_clock_oe,
    output logic out_data,
    // status
    output logic [7:0] sample_rate_ratio,
    output logic converter_unlock_irq,
    output logic converter_overflow_irq,
    output logic sample_slip_irq,
    output logic in_word_clock_lead
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    function automatic logic [6:0] half_of(input logic [1:0] r);
        unique case (r)
            2'h0: half_of = rcsp_pkg::HALF_RATE0;
            2'h1: half_of = rcsp_pkg::HALF_RATE1;
            2'h2: half_of = rcsp_pkg::HALF_RATE2;
            2'h3: half_of = rcsp_pkg::HALF_RATE3;
        endcase
    endfunction

    // code 11 is not a word length; treat as 24
    function automatic logic [4:0] res_bits(input logic [1:0] r);
        unique case (r)
            rcsp_pkg::RES_20: res_bits = rcsp_pkg::BITS_20;
            rcsp_pkg::RES_16: res_bits = rcsp_pkg::BITS_16;
            rcsp_pkg::RES_24: res_bits = rcsp_pkg::BITS_24;
            rcsp_pkg::RES_RAW: res_bits = rcsp_pkg::BITS_24;
        endcase
    endfunction

    // low n bits of sr moved to the msb end
    function automatic logic [23:0] align(input logic [23:0] sr, input logic [4:0] n);
        logic [23:0] m;
        m = (n >= rcsp_pkg::BITS_24) ? 24'hffffff : ((24'h1 << n) - 24'h1);
        align = (sr & m) << (rcsp_pkg::BITS_24 - n);
    endfunction

    // dither below the kept lsb, saturate, then truncate
    function automatic logic [23:0] shorten(input logic [23:0] w, input logic [23:0] rnd,
                                            input logic [4:0] n, input logic off);
        logic [23:0] low;
        logic [24:0] s;
        low = (24'h1 << (rcsp_pkg::BITS_24 - n)) - 24'h1;
        s = {w[23], w} + {1'b0, off ? 24'h0 : (rnd & low)};
        if (!w[23] && s[23]) s = {1'b0, rcsp_pkg::SAT_POS};
        shorten = s[23:0] & ~low;
    endfunction

    // per port: synchronisers, master clock divider, edge detection
    rcsp_pkg::rcsp_port_cfg_s cfg [2];
    logic bclk_pin [2];
    logic wclk_pin [2];
    logic gen_b [2];
    logic gen_l [2];
    logic nb [2];
    logic lft [2];
    logic rise [2];
    logic fall [2];
    assign cfg[0] = in_cfg;
    assign cfg[1] = out_cfg;
    assign bclk_pin[0] = in_bit_clock_i;
    assign bclk_pin[1] = out_bit_clock_i;
    assign wclk_pin[0] = in_word_clock_i;
    assign wclk_pin[1] = out_word_clock_i;

    genvar p;
    for (p = 0; p < 2; p++) begin : g_port
        logic [1:0] bsync;
        logic [1:0] wsync;
        logic [6:0] hcnt;
        logic [5:0] bits;
        logic nb_prev;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                bsync <= 2'h0;
                wsync <= 2'h0;
            end else begin
                bsync <= {bsync[0], bclk_pin[p]};
                wsync <= {wsync[0], wclk_pin[p]};
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                hcnt <= 7'h0;
                gen_b[p] <= 1'b0;
                bits <= 6'h0;
            end else if (hcnt >= half_of(cfg[p].bitclk_rate) - 7'h1) begin
                hcnt <= 7'h0;
                gen_b[p] <= ~gen_b[p];
                if (gen_b[p]) bits <= bits + 6'h1;
            end else begin
                hcnt <= hcnt + 7'h1;
            end
        end
        assign gen_l[p] = bits[5];
        assign nb[p] = cfg[p].master ? gen_b[p] : (bsync[1] ^ cfg[p].bitclk_polarity);
        assign lft[p] = cfg[p].master ? gen_l[p] : (wsync[1] ^ cfg[p].wordclk_polarity);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) nb_prev <= 1'b0;
            else nb_prev <= nb[p];
        end
        assign rise[p] = nb[p] & ~nb_prev;
        assign fall[p] = ~nb[p] & nb_prev;
    end

    // pins show the normalised clocks with the chosen polarity
    assign in_bit_clock_o = gen_b[0] ^ in_cfg.bitclk_polarity;
    assign in_word_clock_o = gen_l[0] ^ in_cfg.wordclk_polarity;
    assign in_bit_clock_oe = in_cfg.master;
    assign in_word_clock_oe = in_cfg.master;
    assign out_bit_clock_o = gen_b[1] ^ out_cfg.bitclk_polarity;
    assign out_word_clock_o = gen_l[1] ^ out_cfg.wordclk_polarity;
    assign out_bit_clock_oe = out_cfg.master;
    assign out_word_clock_oe = out_cfg.master;

    // serial input deserialiser
    logic [1:0] dsync;
    logic [23:0] isr;
    logic [4:0] icnt;
    logic [4:0] in_n;
    logic [4:0] in_res;
    logic il_prev;
    logic [23:0] il_word;
    logic [23:0] word_done;
    rcsp_pkg::rcsp_stereo_s in_pair;
    logic in_pair_valid;

    assign in_res = res_bits(in_cfg.resolution);
    assign in_n = (in_cfg.justify && in_res < icnt) ? in_res : icnt;
    assign word_done = align(isr, in_n);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) dsync <= 2'h0;
        else dsync <= {dsync[0], in_data};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            isr <= 24'h0;
            icnt <= 5'h0;
            il_prev <= 1'b0;
            il_word <= 24'h0;
            in_pair <= '0;
            in_pair_valid <= 1'b0;
            in_word_clock_lead <= 1'b0;
        end else begin
            in_pair_valid <= 1'b0;
            in_word_clock_lead <= 1'b0;
            if (rise[0]) begin
                il_prev <= lft[0];
                if (lft[0] != il_prev) begin
                    in_word_clock_lead <= lft[0];
                    if (il_prev) begin
                        il_word <= word_done;
                    end else begin
                        in_pair <= {il_word, word_done};
                        in_pair_valid <= 1'b1;
                    end
                    if (in_cfg.first_bit_delay) begin
                        isr <= 24'h0;
                        icnt <= 5'h0;
                    end else begin
                        isr <= {23'h0, dsync[1]};
                        icnt <= 5'h1;
                    end
                end else if (in_cfg.justify || icnt < rcsp_pkg::BITS_24) begin
                    isr <= {isr[22:0], dsync[1]};
                    if (icnt < rcsp_pkg::BITS_24) icnt <= icnt + 5'h1;
                end
            end
        end
    end

    // sample buffer between the two rate domains
    logic fifo_in_valid;
    logic fifo_s_ready;
    logic fifo_m_valid;
    logic overflow_now;
    logic frame_start;
    logic ophase_start;
    rcsp_pkg::rcsp_stereo_s fifo_in;
    rcsp_pkg::rcsp_stereo_s fifo_out;

    assign fifo_in_valid = src_from_rx ? rx_valid : in_pair_valid;
    assign fifo_in = src_from_rx ? rx_sample : in_pair;
    assign overflow_now = fifo_in_valid & ~fifo_s_ready;

    rcsp_fifo #(
        .WIDTH($bits(rcsp_pkg::rcsp_stereo_s)),
        .DEPTH(rcsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .s_valid(fifo_in_valid),
        .s_ready(fifo_s_ready),
        .s_data(fifo_in),
        .m_valid(fifo_m_valid),
        .m_ready(frame_start),
        .m_data(fifo_out)
    );

    // output length and independent dither per channel
    logic [23:0] lfsr [2];
    logic [23:0] dith [2];
    logic [4:0] n_out;
    assign n_out = res_bits(out_cfg.resolution);

    genvar c;
    for (c = 0; c < 2; c++) begin : g_dith
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) lfsr[c] <= (c == 0) ? rcsp_pkg::DITH_SEED_L : rcsp_pkg::DITH_SEED_R;
            else if (lfsr[c][0]) lfsr[c] <= (lfsr[c] >> 1) ^
                ((c == 0) ? rcsp_pkg::DITH_TAPS_L : rcsp_pkg::DITH_TAPS_R);
            else lfsr[c] <= lfsr[c] >> 1;
        end
        assign dith[c] = shorten((c == 0) ? fifo_out.left : fifo_out.right,
                                 lfsr[c], n_out, dither_off);
    end

    // serial output serialiser
    rcsp_pkg::rcsp_stereo_s cur;
    logic ol_prev;
    logic [31:0] osr;
    logic [31:0] w_sel;
    logic [23:0] ch_word;
    rcsp_pkg::rcsp_raw_s ch_raw;

    assign ophase_start = fall[1] & (lft[1] != ol_prev);
    assign frame_start = ophase_start & lft[1];
    assign ch_word = lft[1] ? (fifo_m_valid ? dith[0] : cur.left) : cur.right;
    assign ch_raw = lft[1] ? rx_raw_left : rx_raw_right;

    always_comb begin
        w_sel = 32'h0;
        if (out_cfg.resolution == rcsp_pkg::RES_RAW) begin
            if (out_clk_recovered) w_sel = {ch_word, ch_raw, rx_block_start_pin, 4'h0};
        end else if (out_cfg.justify) begin
            w_sel = {8'h0, ch_word} >> (rcsp_pkg::BITS_24 - n_out);
        end else begin
            w_sel = {ch_word, 8'h0};
        end
        if (out_cfg.first_bit_delay) w_sel = w_sel >> 1;
        if (out_mute) w_sel = 32'h0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            ol_prev <= 1'b0;
            osr <= 32'h0;
            out_data <= 1'b0;
        end else begin
            if (frame_start && fifo_m_valid) cur <= {dith[0], dith[1]};
            if (fall[1]) ol_prev <= lft[1];
            if (ophase_start) begin
                out_data <= w_sel[31];
                osr <= {w_sel[30:0], 1'b0};
            end else if (fall[1]) begin
                out_data <= ~out_mute & osr[31];
                osr <= {osr[30:0], 1'b0};
            end else if (out_mute) begin
                out_data <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_overflow_irq <= 1'b0;
            sample_slip_irq <= 1'b0;
        end else begin
            converter_overflow_irq <= overflow_now;
            sample_slip_irq <= ~out_cfg.master &
                ((frame_start & ~fifo_m_valid) | overflow_now);
        end
    end

    // ratio measurement over 64 output frames and settling
    logic [7:0] in_cnt;
    logic [5:0] ofr;
    logic [13:0] settle;
    logic ratio_wrap;
    logic ratio_change;

    assign ratio_wrap = frame_start & (ofr == rcsp_pkg::RATIO_WIN_LAST);
    assign ratio_change =
        ({1'b0, in_cnt} > {1'b0, sample_rate_ratio} + {1'b0, rcsp_pkg::RATIO_TOL}) ||
        ({1'b0, sample_rate_ratio} > {1'b0, in_cnt} + {1'b0, rcsp_pkg::RATIO_TOL});

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ofr <= 6'h0;
            in_cnt <= 8'h0;
            sample_rate_ratio <= rcsp_pkg::RATIO_UNITY;
        end else begin
            if (frame_start) ofr <= ofr + 6'h1;
            if (ratio_wrap) begin
                in_cnt <= {7'h0, fifo_in_valid};
                sample_rate_ratio <= in_cnt;
            end else if (fifo_in_valid && in_cnt != rcsp_pkg::RATIO_MAX) begin
                in_cnt <= in_cnt + 8'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle <= 14'(SETTLE_POWERUP);
            converter_unlock_irq <= 1'b1;
        end else begin
            if (!recovery_locked) settle <= 14'(SETTLE_POWERUP);
            else if (ratio_wrap && ratio_change) settle <= 14'(SETTLE_CHANGE);
            else if (frame_start && settle != 14'h0) settle <= settle - 14'h1;
            converter_unlock_irq <= (settle != 14'h0) | ~recovery_locked;
        end
    end

    chk_overflow_flag: assert property (overflow_now |=> converter_overflow_irq)
        else $error("overflow event not flagged");
    chk_unlock_hold: assert property (settle != 14'h0 |=> converter_unlock_irq)
        else $error("unlock dropped while settling");
    chk_settle_reload: assert property (recovery_locked && ratio_wrap && ratio_change
        |=> settle == 14'(SETTLE_CHANGE))
        else $error("settle not reloaded on ratio change");
    chk_recovery_sum: assert property (!recovery_locked
        |=> settle == 14'(SETTLE_POWERUP) ##1 converter_unlock_irq)
        else $error("settle counted before recovery lock");
    chk_ratio_load: assert property (ratio_wrap |=> sample_rate_ratio == $past(in_cnt))
        else $error("ratio register not loaded");
    chk_mute_zero: assert property (out_mute |=> !out_data)
        else $error("data not muted");
    chk_slip_flag: assert property (frame_start && !fifo_m_valid && !out_cfg.master
        |=> sample_slip_irq)
        else $error("repeated sample not flagged");
    chk_rj_trunc: assert property (in_pair_valid && in_cfg.justify && $stable(in_cfg) &&
        in_cfg.resolution == rcsp_pkg::RES_16 |-> in_pair.right[7:0] == 8'h0)
        else $error("right-justified input not truncated");
    chk_out_len: assert property (frame_start && fifo_m_valid &&
        out_cfg.resolution == rcsp_pkg::RES_16 |=> cur.left[7:0] == 8'h0)
        else $error("output length not applied");
    chk_master_clock: assert property (out_cfg.master && $stable(out_cfg)
        |-> ##[1:40] $changed(out_bit_clock_o))
        else $error("master bit clock stalled");

    cov_overflow: cover property (converter_overflow_irq);
    cov_slip: cover property (sample_slip_irq);
    cov_unlock_release: cover property ($fell(converter_unlock_irq));
    cov_raw_frame: cover property (frame_start && out_clk_recovered &&
        out_cfg.resolution == rcsp_pkg::RES_RAW);
endmodule // rcsp_top

// [verification/rcsp_audio_peer.sv]
// Purpose: audio source on the input port and audio sink on the output port
// Assumes: input port slave, output port master, left-justified, polarities 0
// Notes: source frame is 64 bit clocks of 8 clk; sink keeps the 24-bit left word
`timescale 1ns/10ps

module rcsp_audio_peer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // source side
    input wire logic [23:0] src_word,
    output logic src_bclk,
    output logic src_wclk,
    output logic src_data,
    // sink side
    input wire logic snk_bclk,
    input wire logic snk_wclk,
    input wire logic snk_data,
    output logic [23:0] snk_word,
    output logic snk_done
);
    logic [1:0] div;
    logic [5:0] slot;
    logic bclk_q, wclk_q;
    logic [4:0] cnt;
    logic [23:0] shift;

    // clocks run on without gaps, data changes on the falling bit edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 2'h0;
            slot <= 6'h00;
            src_bclk <= 1'b0;
            src_wclk <= 1'b0;
            src_data <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                src_bclk <= ~src_bclk;
                if (src_bclk) begin
                    slot <= slot + 6'h01;
                    src_wclk <= ~slot[5];
                    // unused slots toggle so that stray bits show
                    src_data <= (slot[4:0] < 5'h18) ? src_word[5'h17 - slot[4:0]] : ~src_data;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_q <= 1'b0;
            wclk_q <= 1'b0;
            cnt <= 5'h00;
            shift <= 24'h000000;
            snk_word <= 24'h000000;
            snk_done <= 1'b0;
        end else begin
            bclk_q <= snk_bclk;
            snk_done <= 1'b0;
            if (snk_bclk && !bclk_q) begin
                wclk_q <= snk_wclk;
                if (snk_wclk && !wclk_q) begin
                    cnt <= 5'h01;
                    shift <= {23'h000000, snk_data};
                end else if (cnt != 5'h00) begin
                    cnt <= cnt + 5'h01;
                    shift <= {shift[22:0], snk_data};
                    if (cnt == 5'h17) begin
                        snk_word <= {shift[22:0], snk_data};
                        snk_done <= 1'b1;
                        cnt <= 5'h00;
                    end
                end
            end
        end
    end
endmodule // rcsp_audio_peer

// [verification/rcsp_top_tb.sv]
// Purpose: self-checking bench of the rate converter and serial ports
// Assumes: settle counts shortened to 20 and 10 output frames
// Notes: output port master at rate code 0, input port slave
`timescale 1ns/10ps

module rcsp_top_tb;
    logic clk, rst_n, src_from_rx, dither_off, out_mute, recovery_locked, rx_valid;
    rcsp_pkg::rcsp_port_cfg_s in_cfg, out_cfg;
    rcsp_pkg::rcsp_stereo_s rx_sample;
    rcsp_pkg::rcsp_raw_s raw;
    logic [23:0] src_word, snk_word;
    logic src_bclk, src_wclk, src_data, snk_done, out_bclk, out_wclk, out_dat;
    logic in_oe, out_oe, unlock, ovf, lead, slip, out_rec;
    logic [7:0] ratio;
    int mismatches, n_checks;

    rcsp_top #(.SETTLE_CHANGE(20), .SETTLE_POWERUP(10)) u_dut (
        .clk(clk), .rst_n(rst_n), .in_cfg(in_cfg), .out_cfg(out_cfg),
        .src_from_rx(src_from_rx), .dither_off(dither_off), .out_mute(out_mute),
        .out_clk_recovered(out_rec), .recovery_locked(recovery_locked), .rx_valid(rx_valid),
        .rx_sample(rx_sample), .rx_raw_left(raw), .rx_raw_right(raw),
        .rx_block_start_pin(1'b0), .in_bit_clock_i(src_bclk), .in_bit_clock_o(),
        .in_bit_clock_oe(in_oe), .in_word_clock_i(src_wclk), .in_word_clock_o(),
        .in_word_clock_oe(), .in_data(src_data), .out_bit_clock_i(1'b0),
        .out_bit_clock_o(out_bclk), .out_bit_clock_oe(out_oe), .out_word_clock_i(1'b0),
        .out_word_clock_o(out_wclk), .out_word_clock_oe(), .out_data(out_dat),
        .sample_rate_ratio(ratio), .converter_unlock_irq(unlock),
        .converter_overflow_irq(ovf), .sample_slip_irq(slip), .in_word_clock_lead(lead));

    rcsp_audio_peer u_peer (
        .clk(clk), .rst_n(rst_n), .src_word(src_word), .src_bclk(src_bclk),
        .src_wclk(src_wclk), .src_data(src_data), .snk_bclk(out_bclk), .snk_wclk(out_wclk),
        .snk_data(out_dat), .snk_word(snk_word), .snk_done(snk_done));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic wait_done;
        int i;
        for (i = 0; i < 1200 && snk_done !== 1'b1; i++) @(negedge clk);
        if (i == 1200) begin
            mismatches++;
            $display("BAD frame wait exp 1 got 0");
            finish_test();
        end
        @(negedge clk);
    endtask

    task automatic expect_word(input logic [23:0] exp);
        int i;
        for (i = 0; i < 40; i++) begin
            wait_done();
            if (snk_word === exp) break;
        end
        check("left word", exp, snk_word);
    endtask

    task automatic t_reset;
        @(negedge clk);
        check("ratio at reset", 24'(rcsp_pkg::RATIO_UNITY), 24'(ratio));
        check("unlock at reset", 24'h1, 24'(unlock));
        check("master clock enable", 24'h1, 24'(out_oe));
        check("slave clock enable", 24'h0, 24'(in_oe));
    endtask

    task automatic t_lock;
        int i;
        repeat (12) wait_done();
        check("unlock while recovery unlocked", 24'h1, 24'(unlock));
        @(posedge clk) recovery_locked <= 1'b1;
        for (i = 0; i < 14 && unlock !== 1'b0; i++) wait_done();
        check("unlock after settle", 24'h0, 24'(unlock));
    endtask

    task automatic t_clock_rate;
        int hi;
        int n;
        hi = 0;
        n = 0;
        // source frame is exactly 512 clk, so one leading edge per window
        repeat (512) begin
            @(negedge clk);
            n += (lead === 1'b1);
        end
        check("word clock leads per frame", 24'h1, 24'(n));
        for (int i = 0; i < 100 && out_bclk !== 1'b0; i++) @(negedge clk);
        for (int i = 0; i < 100 && out_bclk !== 1'b1; i++) @(negedge clk);
        while (out_bclk === 1'b1 && hi < 100) begin
            @(negedge clk);
            hi++;
        end
        check("bit clock half period", 24'(rcsp_pkg::HALF_RATE0), 24'(hi));
    endtask

    task automatic t_overflow;
        int seen;
        int slips;
        seen = 0;
        slips = 0;
        @(posedge clk);
        src_from_rx <= 1'b1;
        rx_sample <= {24'hc35a96, 24'h0f0f0f};
        rx_valid <= 1'b1;
        // 20 pushes, flags looked at between edges
        for (int i = 0; i < 23; i++) begin
            @(negedge clk);
            seen += (ovf === 1'b1);
            slips += (slip === 1'b1);
            if (i == 19) @(posedge clk) rx_valid <= 1'b0;
        end
        check("overflow pulse seen", 24'h1, 24'(seen > 0));
        check("slip pulses with master output", 24'h0, 24'(slips));
        expect_word(24'hc35a96);
    endtask

    task automatic t_mute;
        @(posedge clk) out_mute <= 1'b1;
        wait_done();
        expect_word(24'h000000);
        @(posedge clk) out_mute <= 1'b0;
        expect_word(24'hc35a96);
    endtask

    task automatic t_out_formats;
        @(posedge clk);
        dither_off <= 1'b1;
        out_cfg.resolution <= rcsp_pkg::RES_16;
        rx_sample <= {24'h5a0f3c, 24'h0f0f0f};
        rx_valid <= 1'b1;
        @(posedge clk) rx_valid <= 1'b0;
        expect_word(24'h5a0f00);
        @(posedge clk) out_cfg.resolution <= rcsp_pkg::RES_RAW;
        expect_word(24'h000000);
        @(posedge clk);
        out_rec <= 1'b1;
        raw <= 3'h5;
        rx_sample <= {24'h3c96a5, 24'h0f0f0f};
        rx_valid <= 1'b1;
        @(posedge clk) rx_valid <= 1'b0;
        expect_word(24'h3c96a5);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        in_cfg = '0;
        out_cfg = '0;
        out_cfg.master = 1'b1;
        {src_from_rx, dither_off, out_mute, recovery_locked, rx_valid, out_rec} = 6'h00;
        rx_sample = '0;
        raw = '0;
        src_word = 24'h9e3c71;
        mismatches = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_lock();
        expect_word(24'h9e3c71);
        repeat (45) wait_done();
        check("ratio near unity", 24'h1, 24'(ratio >= 8'h3f && ratio <= 8'h41));
        t_clock_rate();
        t_overflow();
        t_mute();
        t_out_formats();
        finish_test();
    end
endmodule // rcsp_top_tb
